// ===== core/cbmp_top.sv
// core and crossbar memory protection: per-core units plus a crossbar unit
// assumes masters, crossbar and slaves run on clock; descriptors are
// loaded through a plain configuration port, not a software bus
`timescale 1ns/1ps
`default_nettype none
`include "cbmp_params.svh"

module cbmp_top
  import cbmp_pkg::*;
#(
  parameter int ADDR_W = 32,
  parameter int DATA_W = 32,
  parameter int NCORES = `CBMP_CORES,
  parameter int NSREG = `CBMP_SYS_REGIONS,
  parameter int NMAST = `CBMP_MASTERS
) (
  input wire logic clock,
  input wire logic sys_rst,
  // descriptor load port; target below NCORES selects a core unit
  input wire logic cfg_we,
  input wire logic [3:0] cfg_target,
  input wire logic [4:0] cfg_idx,
  input wire logic [ADDR_W-1:0] cfg_start,
  input wire logic [ADDR_W-1:0] cfg_end,
  input wire logic cfg_valid,
  input wire cbmp_rights_t cfg_rights,
  // crossbar descriptor readback
  input wire logic cfg_rd,
  input wire logic [3:0] cfg_rd_idx,
  output logic [ADDR_W-1:0] cfg_rd_start_q,
  output logic [ADDR_W-1:0] cfg_rd_end_q,
  output logic cfg_rd_valid_q,
  output logic [5:0] cfg_rd_rights_q,
  // core access check, one lane per core
  input wire logic [NCORES-1:0] core_req,
  input wire logic [NCORES*ADDR_W-1:0] core_addr,
  input wire logic [NCORES-1:0] core_write,
  input wire logic [NCORES-1:0] core_fetch,
  input wire logic [NCORES-1:0] core_super,
  output logic [NCORES-1:0] core_ok_q,
  output logic [NCORES-1:0] core_err_q,
  // crossbar master side
  input wire logic xb_req,
  input wire logic [1:0] xb_master,
  input wire logic [ADDR_W-1:0] xb_addr,
  input wire logic xb_write,
  input wire logic [DATA_W-1:0] xb_wdata,
  output logic xb_ready_q,
  output logic xb_done_q,
  output logic xb_err_q,
  output logic [DATA_W-1:0] xb_rdata_q,
  // crossbar slave side
  output logic slv_req_q,
  output logic [ADDR_W-1:0] slv_addr_q,
  output logic slv_write_q,
  output logic [DATA_W-1:0] slv_wdata_q,
  input wire logic slv_ack,
  input wire logic [DATA_W-1:0] slv_rdata
);
  // ==========================================================
  // core-level units, one per core
  for (genvar c = 0; c < NCORES; c++) begin : g_core
    logic sel_we;
    assign sel_we = cfg_we && (cfg_target == 4'(c));
    cbmp_core_unit #(
      .ADDR_W(ADDR_W),
      .NREG(`CBMP_CORE_REGIONS)
    ) u_unit (
      .clock(clock),
      .sys_rst(sys_rst),
      .cfg_we(sel_we),
      .cfg_idx(cfg_idx),
      .cfg_start(cfg_start),
      .cfg_end(cfg_end),
      .cfg_valid(cfg_valid),
      .cfg_rights(cfg_rights),
      .req(core_req[c]),
      .addr(core_addr[c*ADDR_W +: ADDR_W]),
      .write(core_write[c]),
      .fetch(core_fetch[c]),
      .sup_mode(core_super[c]),
      .ok_q(core_ok_q[c]),
      .err_q(core_err_q[c])
    );
  end

  // ==========================================================
  // crossbar descriptor table
  logic [ADDR_W-1:0] s_start_q [NSREG];
  logic [ADDR_W-1:0] s_end_q [NSREG];
  cbmp_rights_t s_rights_q [NSREG];
  logic [NSREG-1:0] s_valid_q;
  logic sys_we;

  // any target at or above NCORES addresses the crossbar table
  assign sys_we = cfg_we && (cfg_target >= 4'(NCORES));

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      s_valid_q <= '0;
    end else if (sys_we) begin
      s_valid_q[cfg_idx[3:0]] <= cfg_valid;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_we) begin
      s_start_q[cfg_idx[3:0]] <= cfg_start;
      s_end_q[cfg_idx[3:0]] <= cfg_end;
      s_rights_q[cfg_idx[3:0]] <= cfg_rights;
    end
  end

  // readback shows descriptor contents one cycle after cfg_rd
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      cfg_rd_start_q <= '0;
      cfg_rd_end_q <= '0;
      cfg_rd_valid_q <= 1'b0;
      cfg_rd_rights_q <= `CBMP_RIGHTS_RST;
    end else if (cfg_rd) begin
      cfg_rd_start_q <= s_start_q[cfg_rd_idx];
      cfg_rd_end_q <= s_end_q[cfg_rd_idx];
      cfg_rd_valid_q <= s_valid_q[cfg_rd_idx];
      cfg_rd_rights_q <= s_rights_q[cfg_rd_idx];
    end
  end

  // ==========================================================
  // crossbar check: region dimension against the transfer attributes
  logic [NSREG-1:0] s_grant;
  logic mast_ok;

  // masters beyond the configured set own no rights anywhere
  assign mast_ok = (32'(xb_master) < NMAST);

  for (genvar r = 0; r < NSREG; r++) begin : g_sreg
    logic [1:0] mr;
    logic hit;
    assign mr = s_rights_q[r][xb_master*2 +: 2];
    assign hit = s_valid_q[r] && (xb_addr >= s_start_q[r]) && (xb_addr <= s_end_q[r]);
    assign s_grant[r] = hit && mast_ok && (xb_write ? mr[`CBMP_SR_WR] : mr[`CBMP_SR_RD]);
  end

  // ==========================================================
  // transfer sequencing: one outstanding transfer at a time
  cbmp_xb_state_t st_q;
  logic take;
  logic allow;

  assign take = xb_req && (st_q == CBMP_XB_IDLE);
  assign allow = |s_grant;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      st_q <= CBMP_XB_IDLE;
    end else begin
      case (st_q)
        CBMP_XB_IDLE: begin
          if (take && allow) begin
            st_q <= CBMP_XB_WAIT;
          end
        end
        CBMP_XB_WAIT: begin
          if (slv_ack) begin
            st_q <= CBMP_XB_IDLE;
          end
        end
        default: begin
          st_q <= CBMP_XB_IDLE;
        end
      endcase
    end
  end

  // ready mirrors idle; it drops the cycle after a forwarded transfer
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      xb_ready_q <= 1'b0;
    end else if (st_q == CBMP_XB_IDLE) begin
      xb_ready_q <= !(take && allow);
    end else begin
      xb_ready_q <= slv_ack;
    end
  end

  // slave request holds until ack; a denied transfer never reaches the slave
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      slv_req_q <= 1'b0;
      slv_addr_q <= '0;
      slv_write_q <= 1'b0;
      slv_wdata_q <= `CBMP_DATA_RST;
    end else if (take && allow) begin
      slv_req_q <= 1'b1;
      slv_addr_q <= xb_addr;
      slv_write_q <= xb_write;
      slv_wdata_q <= xb_wdata;
    end else if (slv_ack) begin
      slv_req_q <= 1'b0;
    end
  end

  // master response: slave ack, or an error pulse right after a denial
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      xb_done_q <= 1'b0;
      xb_err_q <= 1'b0;
      xb_rdata_q <= `CBMP_DATA_RST;
    end else if (take && !allow) begin
      xb_done_q <= 1'b1;
      xb_err_q <= 1'b1;
      xb_rdata_q <= `CBMP_DATA_RST;
    end else if (st_q == CBMP_XB_WAIT && slv_ack) begin
      xb_done_q <= 1'b1;
      xb_err_q <= 1'b0;
      xb_rdata_q <= slv_write_q ? `CBMP_DATA_RST : slv_rdata;
    end else begin
      xb_done_q <= 1'b0;
      xb_err_q <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ===== core/cbmp_params.svh
// constants for the core and crossbar memory protection block
// assumes inclusion by bare name from the package and the modules
`ifndef CBMP_PARAMS_SVH
`define CBMP_PARAMS_SVH

// table sizes
`define CBMP_CORE_REGIONS 24
`define CBMP_SYS_REGIONS 16
`define CBMP_MASTERS 3
`define CBMP_CORES 2

// core rights field: supervisor rwx in [5:3], user rwx in [2:0]
`define CBMP_CR_SUP_LSB 3
`define CBMP_CR_USR_LSB 0
`define CBMP_CR_R 2
`define CBMP_CR_W 1
`define CBMP_CR_X 0

// system rights field: master m owns bits [2m+1:2m], write high, read low
`define CBMP_SR_RD 0
`define CBMP_SR_WR 1

// reset values
`define CBMP_RIGHTS_RST 6'h00
`define CBMP_DATA_RST 32'h0000_0000

`endif

// ===== core/cbmp_pkg.sv
// types shared by the protection block modules
// assumes cbmp_params.svh on the include path
`include "cbmp_params.svh"

package cbmp_pkg;
  // crossbar transfer sequencing
  typedef enum logic [0:0] {
    CBMP_XB_IDLE = 1'b0,
    CBMP_XB_WAIT = 1'b1
  } cbmp_xb_state_t;

  typedef logic [5:0] cbmp_rights_t;
endpackage

// ===== core/cbmp_core_unit.sv
// one core-level protection unit: 24 region descriptors, one checker
// assumes requests come from the core on the same clock, one per cycle
`timescale 1ns/1ps
`default_nettype none
`include "cbmp_params.svh"

module cbmp_core_unit
  import cbmp_pkg::*;
#(
  parameter int ADDR_W = 32,
  parameter int NREG = `CBMP_CORE_REGIONS
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic cfg_we,
  input wire logic [$clog2(NREG)-1:0] cfg_idx,
  input wire logic [ADDR_W-1:0] cfg_start,
  input wire logic [ADDR_W-1:0] cfg_end,
  input wire logic cfg_valid,
  input wire cbmp_rights_t cfg_rights,
  input wire logic req,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic write,
  input wire logic fetch,
  input wire logic sup_mode,
  output logic ok_q,
  output logic err_q
);
  // ==========================================================
  // descriptor table
  logic [ADDR_W-1:0] start_q [NREG];
  logic [ADDR_W-1:0] end_q [NREG];
  cbmp_rights_t rights_q [NREG];
  logic [NREG-1:0] valid_q;
  logic [NREG-1:0] grant;

  // only valid bits reset; bounds are don't-care while invalid
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      valid_q <= '0;
    end else if (cfg_we) begin
      valid_q[cfg_idx] <= cfg_valid;
    end
  end

  always_ff @(posedge clock) begin
    if (cfg_we) begin
      start_q[cfg_idx] <= cfg_start;
      end_q[cfg_idx] <= cfg_end;
      rights_q[cfg_idx] <= cfg_rights;
    end
  end

  // ==========================================================
  // parallel match of every entry against the live access
  for (genvar i = 0; i < NREG; i++) begin : g_ent
    logic [2:0] sel;
    logic hit;
    assign sel = sup_mode ? rights_q[i][`CBMP_CR_SUP_LSB +: 3] : rights_q[i][`CBMP_CR_USR_LSB +: 3];
    assign hit = valid_q[i] && (addr >= start_q[i]) && (addr <= end_q[i]);
    assign grant[i] = hit && (fetch ? sel[`CBMP_CR_X] : (write ? sel[`CBMP_CR_W] : sel[`CBMP_CR_R]));
  end

  // verdict one cycle after the request; overlapping entries grant if any grants
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      ok_q <= 1'b0;
      err_q <= 1'b0;
    end else begin
      ok_q <= req && (|grant);
      err_q <= req && !(|grant);
    end
  end
endmodule
`default_nettype wire

// ===== tb/cbmp_monitor.sv
// checker for the protection block, sees the top module's ports only
// assumes one clock domain, synchronous active-high reset
`timescale 1ns/1ps
`default_nettype none

// ==========
// checker
module cbmp_monitor #(
  parameter int NCORES = 2
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic [NCORES-1:0] core_req,
  input wire logic [NCORES-1:0] core_ok_q,
  input wire logic [NCORES-1:0] core_err_q,
  input wire logic xb_req,
  input wire logic xb_ready_q,
  input wire logic xb_done_q,
  input wire logic xb_err_q,
  input wire logic [31:0] xb_rdata_q,
  input wire logic slv_req_q,
  input wire logic [31:0] slv_addr_q,
  input wire logic slv_write_q,
  input wire logic slv_ack,
  input wire logic [31:0] slv_rdata
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (sys_rst);

  // slave finishing a forwarded transfer, then clean completion
  sequence s_fwd;
    slv_req_q && slv_ack;
  endsequence
  sequence s_ok_end;
    xb_done_q && !xb_err_q && !slv_req_q;
  endsequence

  AST_CORE_ANSWER: assert property ((core_ok_q | core_err_q) == $past(core_req))
    else $error("core verdict missing or unrequested");
  AST_CORE_ONE: assert property (core_req != '0 |=> (core_ok_q & core_err_q) == '0)
    else $error("core verdict both ok and err");
  AST_TAKE: assert property (xb_req && xb_ready_q |=> (xb_done_q && xb_err_q) || slv_req_q)
    else $error("taken request neither denied nor forwarded");
  AST_ERR_CLEAN: assert property (xb_err_q |-> xb_done_q && !slv_req_q && xb_rdata_q == '0)
    else $error("denied transfer not clean");
  AST_ACK_DONE: assert property (s_fwd |=> s_ok_end)
    else $error("slave ack not completed");
  AST_ACK_DATA: assert property (s_fwd |=> xb_rdata_q == ($past(slv_write_q) ? '0 : $past(slv_rdata)))
    else $error("read data not passed back");
  AST_SLV_HOLD: assert property (slv_req_q && !slv_ack |=> slv_req_q && $stable(slv_addr_q))
    else $error("slave request dropped or changed");
  AST_DONE_CAUSE: assert property (xb_done_q |-> $past(xb_req) || ($past(slv_req_q) && $past(slv_ack)))
    else $error("done without a cause");
endmodule

bind cbmp_top cbmp_monitor #(.NCORES(NCORES)) mon_u (.*);
`default_nettype wire

// ===== tb/cbmp_slave_model.sv
// crossbar slave model: small word memory, ack after a set delay
// assumes one forwarded request at a time from the crossbar unit
`timescale 1ns/1ps
`default_nettype none

// ==========
// slave
module cbmp_slave_model (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic [3:0] delay,
  input wire logic slv_req_q,
  input wire logic [31:0] slv_addr_q,
  input wire logic slv_write_q,
  input wire logic [31:0] slv_wdata_q,
  output logic slv_ack,
  output logic [31:0] slv_rdata
);
  logic [31:0] mem_q [16];
  logic [3:0] cnt_q;

  // data toggles outside ack so stale values never pass
  always_ff @(posedge clock) begin
    slv_ack <= 1'b0;
    slv_rdata <= ~slv_rdata;
    if (sys_rst) begin
      cnt_q <= 4'h0;
      slv_rdata <= 32'h0;
      for (int i = 0; i < 16; i++) mem_q[i] <= 32'h0;
    end else if (slv_req_q && !slv_ack) begin
      cnt_q <= cnt_q + 4'h1;
      if (cnt_q == delay) begin
        cnt_q <= 4'h0;
        slv_ack <= 1'b1;
        slv_rdata <= mem_q[slv_addr_q[5:2]];
        if (slv_write_q) mem_q[slv_addr_q[5:2]] <= slv_wdata_q;
      end
    end
  end
endmodule
`default_nettype wire

// ===== tb/cbmp_top_test.sv
// testbench for the protection block: core lanes, crossbar, readback
// assumes the slave model on the crossbar slave side
`timescale 1ns/1ps
`default_nettype none

// ==========
// bench
module cbmp_top_test
  import cbmp_pkg::*;
;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic cfg_we = 1'b0, cfg_valid = 1'b0, cfg_rd = 1'b0, xb_req = 1'b0, xb_write = 1'b0;
  logic [3:0] cfg_target = 4'h0, cfg_rd_idx = 4'h0, slv_delay = 4'h0;
  logic [4:0] cfg_idx = 5'h00;
  logic [31:0] cfg_start = 32'h0, cfg_end = 32'h0, xb_addr = 32'h0, xb_wdata = 32'h0;
  cbmp_rights_t cfg_rights = 6'h00;
  logic [1:0] core_req = 2'h0, core_write = 2'h0, core_fetch = 2'h0, core_super = 2'h0, xb_master = 2'h0;
  logic [63:0] core_addr = 64'h0;
  logic [31:0] cfg_rd_start_q, cfg_rd_end_q, xb_rdata_q, slv_addr_q, slv_wdata_q, slv_rdata;
  logic [5:0] cfg_rd_rights_q;
  logic [1:0] core_ok_q, core_err_q;
  logic cfg_rd_valid_q, xb_ready_q, xb_done_q, xb_err_q, slv_req_q, slv_write_q, slv_ack;
  int num_errors = 0, total_checks = 0, cycles = 0;

  cbmp_top dut_u (.*);
  cbmp_slave_model slave_u (.*, .delay(slv_delay));

  always #4 clock = ~clock;

  task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic cfg_write(input logic [3:0] t, input logic [4:0] i, input logic [31:0] s, e,
                           input logic v, input cbmp_rights_t r);
    {cfg_we, cfg_target, cfg_idx, cfg_start, cfg_end, cfg_valid, cfg_rights} = {1'b1, t, i, s, e, v, r};
    @(negedge clock);
    cfg_we = 1'b0;
    @(negedge clock);
  endtask

  // both lanes see the same access; wfs is write, fetch, supervisor
  task automatic core_chk(input logic [31:0] a, input logic [2:0] wfs, input logic [1:0] ok);
    core_req = 2'h3;
    core_addr = {a, a};
    {core_write, core_fetch, core_super} = {{2{wfs[2]}}, {2{wfs[1]}}, {2{wfs[0]}}};
    @(negedge clock);
    check("core_ok", ok, core_ok_q);
    check("core_err", {~ok}, core_err_q);
  endtask

  // request raised only while ready, so the next edge takes it; extra cycle keeps strobes apart
  task automatic xb_xfer(input logic [1:0] m, input logic [31:0] a, input logic w, input logic [31:0] d,
                         input logic err, input logic [31:0] rd);
    int n = 0;
    while (xb_ready_q !== 1'b1 && n < 30) begin
      @(negedge clock);
      n++;
    end
    n = 0;
    {xb_req, xb_master, xb_addr, xb_write, xb_wdata} = {1'b1, m, a, w, d};
    @(negedge clock);
    xb_req = 1'b0;
    check("xb_busy", err, xb_ready_q);
    while (xb_done_q !== 1'b1 && n < 30) begin
      @(negedge clock);
      n++;
    end
    check("xb_done", 1'b1, xb_done_q);
    check("xb_err", err, xb_err_q);
    check("xb_rdata", rd, xb_rdata_q);
    check("xb_ready", 1'b1, xb_ready_q);
    @(negedge clock);
  endtask

  // nothing valid after reset
  task automatic t_after_reset();
    core_chk(32'h0000_1000, 3'b001, 2'h0);
    core_req = 2'h0;
    xb_xfer(2'h0, 32'h0000_0010, 1'b0, 32'h0, 1'b1, 32'h0);
    $display("test after_reset done");
  endtask

  // reset in mid-run clears the valid bits of both tables
  task automatic t_mid_reset();
    sys_rst = 1'b1;
    repeat (2) @(negedge clock);
    sys_rst = 1'b0;
    core_chk(32'h0000_1800, 3'b100, 2'h0);
    core_req = 2'h0;
    xb_xfer(2'h0, 32'h0000_0040, 1'b0, 32'h0, 1'b1, 32'h0);
    $display("test mid_reset done");
  endtask

  // lane 0 entry 23: supervisor rwx, user read; lane 1 empty at first
  task automatic t_core_rights();
    cfg_write(4'h0, 5'd23, 32'h0000_1000, 32'h0000_1fff, 1'b1, 6'h3c);
    core_chk(32'h0000_1000, 3'b000, 2'h1);
    core_chk(32'h0000_1000, 3'b100, 2'h0);
    core_chk(32'h0000_1000, 3'b010, 2'h0);
    core_chk(32'h0000_1000, 3'b101, 2'h1);
    core_chk(32'h0000_1fff, 3'b111, 2'h1);
    core_chk(32'h0000_2000, 3'b001, 2'h0);
    core_chk(32'h0000_0fff, 3'b001, 2'h0);
    core_req = 2'h0;
    cfg_write(4'h1, 5'd0, 32'h0000_1000, 32'h0000_1fff, 1'b1, 6'h02);
    core_chk(32'h0000_1800, 3'b100, 2'h2);
    core_req = 2'h0;
    cfg_write(4'h0, 5'd23, 32'h0000_1000, 32'h0000_1fff, 1'b0, 6'h3c);
    core_chk(32'h0000_1000, 3'b000, 2'h0);
    core_req = 2'h0;
    $display("test core_rights done");
  endtask

  // region 15: core rw, dma read; region 0: serial master write only
  task automatic t_crossbar_switch();
    cfg_write(4'h2, 5'd15, 32'h0, 32'h0000_00ff, 1'b1, 6'h07);
    cfg_write(4'h2, 5'd0, 32'h0000_0200, 32'h0000_02ff, 1'b1, 6'h20);
    cfg_rd_idx = 4'hf;
    cfg_rd = 1'b1;
    @(negedge clock);
    cfg_rd_idx = 4'h0;
    check("rd_start", 32'h0, cfg_rd_start_q);
    check("rd_end", 32'h0000_00ff, cfg_rd_end_q);
    check("rd_valid", 1'b1, cfg_rd_valid_q);
    check("rd_rights", 6'h07, cfg_rd_rights_q);
    @(negedge clock);
    cfg_rd = 1'b0;
    check("rd_start", 32'h0000_0200, cfg_rd_start_q);
    check("rd_end", 32'h0000_02ff, cfg_rd_end_q);
    check("rd_rights", 6'h20, cfg_rd_rights_q);
    xb_xfer(2'h0, 32'h0000_0040, 1'b1, 32'h0000_00a5, 1'b0, 32'h0);
    xb_xfer(2'h1, 32'h0000_0040, 1'b1, 32'h0000_003c, 1'b1, 32'h0);
    slv_delay = 4'h5;
    xb_xfer(2'h1, 32'h0000_0040, 1'b0, 32'h0, 1'b0, 32'h0000_00a5);
    xb_xfer(2'h2, 32'h0000_0040, 1'b0, 32'h0, 1'b1, 32'h0);
    xb_xfer(2'h2, 32'h0000_0204, 1'b1, 32'h0000_5a5a, 1'b0, 32'h0);
    xb_xfer(2'h0, 32'h0000_0204, 1'b0, 32'h0, 1'b1, 32'h0);
    xb_xfer(2'h3, 32'h0000_0040, 1'b0, 32'h0, 1'b1, 32'h0);
    xb_xfer(2'h0, 32'h0000_0100, 1'b0, 32'h0, 1'b1, 32'h0);
    $display("test crossbar_switch done");
  endtask

  task automatic end_of_test();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // fewer than a hundred cycles are needed; cut a hang short
  always @(posedge clock) begin
    cycles++;
    if (cycles == 3000) begin
      num_errors++;
      end_of_test();
    end
  end

  initial begin
    repeat (12) @(negedge clock);
    sys_rst = 1'b0;
    t_after_reset();
    t_core_rights();
    t_crossbar_switch();
    t_mid_reset();
    end_of_test();
  end
endmodule
`default_nettype wire
